// [hw/mlic_pkg.sv]
/*
 Constants, state codes and register map of the multilevel interrupt controller.
 Assumes a 32-bit APB slave with one register per aligned word; byte address is four times the index.
*/
package mlic_pkg;

   // Register indices; byte address is index times four
   localparam logic [7:0] MLIC_IDX_STATUS = 8'h00;
   localparam logic [7:0] MLIC_IDX_INTPRI = 8'h01;
   localparam logic [7:0] MLIC_IDX_CTRL   = 8'h02;
   localparam logic [7:0] MLIC_IDX_LEVEL  = 8'h03;
   localparam logic [7:0] MLIC_IDX_FLAG   = 8'h04;
   localparam int         MLIC_WORD_BYTES = 4;

   // Status register bits
   localparam int MLIC_ST_LO_BIT  = 0;
   localparam int MLIC_ST_MED_BIT = 1;
   localparam int MLIC_ST_HI_BIT  = 2;
   localparam int MLIC_ST_NMI_BIT = 7;

   // Control register bits
   localparam int MLIC_CT_LO_BIT    = 0;
   localparam int MLIC_CT_MED_BIT   = 1;
   localparam int MLIC_CT_HI_BIT    = 2;
   localparam int MLIC_CT_IVSEL_BIT = 6;
   localparam int MLIC_CT_RREN_BIT  = 7;

   // Reset values
   localparam logic [31:0] MLIC_RST_WORD = 32'h0000_0000;

   // Per-source level codes
   localparam logic [1:0] MLIC_LVL_OFF = 2'b00;
   localparam logic [1:0] MLIC_LVL_LO  = 2'b01;
   localparam logic [1:0] MLIC_LVL_MED = 2'b10;
   localparam logic [1:0] MLIC_LVL_HI  = 2'b11;

   // Running level ranks, NMI above high
   localparam logic [2:0] MLIC_RANK_NONE = 3'h0;
   localparam logic [2:0] MLIC_RANK_LO   = 3'h1;
   localparam logic [2:0] MLIC_RANK_MED  = 3'h2;
   localparam logic [2:0] MLIC_RANK_HI   = 3'h3;
   localparam logic [2:0] MLIC_RANK_NMI  = 3'h4;

   // Timing counts in CPU clock cycles
   localparam logic [7:0] MLIC_FINISH_CYC = 8'h01;
   localparam logic [7:0] MLIC_PUSH_CYC   = 8'h02;
   localparam logic [7:0] MLIC_JUMP_CYC   = 8'h03;
   localparam logic [7:0] MLIC_WAKE_CYC   = 8'h05;
   localparam logic [7:0] MLIC_INTERRUPT_RETURN_INSTR_SHORT = 8'h04;
   localparam logic [7:0] MLIC_INTERRUPT_RETURN_INSTR_LONG  = 8'h05;
   localparam logic [2:0] MLIC_CCP_CYC    = 3'h4;

   typedef enum logic [2:0] {
      MLIC_ST_IDLE   = 3'b000,
      MLIC_ST_WAKE   = 3'b001,
      MLIC_ST_FINISH = 3'b010,
      MLIC_ST_PUSH   = 3'b011,
      MLIC_ST_JUMP   = 3'b100,
      MLIC_ST_INTERRUPT_RETURN_INSTR   = 3'b101
   } mlic_st_e;

endpackage

// [hw/mlic_arbiter.sv]
/*
 Fixed or rotating priority pick among request lines.
 Assumes start names the index with the highest priority; search runs upward and wraps.
*/
`timescale 1ns/1ns
module mlic_arbiter #(
   parameter int N  = 8,
   parameter int IW = 3
) (
   input  wire logic [N-1:0]  req_in,
   input  wire logic [IW-1:0] start_in,
   output logic               found_out,
   output logic [IW-1:0]      idx_out
);
   int j;

   always_comb begin
      j         = 0;
      found_out = 1'b0;
      idx_out   = '0;
      for (int k = 0; k < N; k++) begin
         j = (int'(start_in) + k) % N;
         if (!found_out && req_in[j]) begin
            found_out = 1'b1;
            idx_out   = IW'(j);
         end
      end
   end
endmodule // mlic_arbiter

// [hw/multilevel_irq_ctrl.sv]
/*
 Multilevel interrupt controller: flags, level arbitration, nesting state, response sequencing, APB registers.
 Assumes the CPU pulses instr_retire_in per finished instruction and interrupt_return_instr_in on an interrupt return,
 and stalls while cpu_hold_out is high; the global enable arrives as gie_in and is never written here.
*/
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module multilevel_irq_ctrl
#(
   parameter int               N           = 8,
   parameter int               AW          = 16,
   parameter logic [N-1:0]     NMI_MASK    = 8'h01,
   parameter logic [N-1:0]     AUTOCLR     = 8'hff,
   parameter logic [AW-1:0]    APP_BASE    = 16'h0000,
   parameter logic [AW-1:0]    BOOT_BASE   = 16'h1000,
   parameter logic [AW-1:0]    VEC_STRIDE  = 16'h0002,
   parameter logic [7:0]       STARTUP_CYC = 8'h04,
   parameter bit               WIDE_PC     = 1'b0
) (
   input  wire logic           sys_clk_in,
   input  wire logic           rst_b_in,
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire logic [11:0]    paddr_in,
   input  wire logic [31:0]    pwdata_in,
   output logic      [31:0]    prdata_out,
   output logic                pready_out,
   output logic                pslverr_out,
   input  wire logic           gie_in,
   input  wire logic           instr_retire_in,
   input  wire logic           interrupt_return_instr_in,
   input  wire logic           sleep_in,
   input  wire logic           ccp_sig_in,
   input  wire logic           locked_exec_in,
   input  wire logic [N-1:0]   irq_cond_in,
   input  wire logic [N-1:0]   access_clr_in,
   output logic                vec_load_out,
   output logic      [AW-1:0]  vec_addr_out,
   output logic                cpu_hold_out,
   output logic      [3:0]     exec_status_out
);
   import mlic_pkg::*;

   localparam int IW       = $clog2(N);
   localparam int WAKE_LEN = int'(MLIC_WAKE_CYC) + int'(STARTUP_CYC);

   typedef struct packed {
      mlic_st_e        st;
      logic [7:0]      cnt;
      logic [N-1:0]    flag;
      logic [2*N-1:0]  lvl;
      logic [7:0]      intpri;
      logic            rren;
      logic            ivsel;
      logic            hi_en;
      logic            med_en;
      logic            lo_en;
      logic            nmi_ex;
      logic            hi_ex;
      logic            med_ex;
      logic            lo_ex;
      logic            instr_done;
      logic [2:0]      ccp_cnt;
      logic [IW-1:0]   sel;
      logic [2:0]      sel_rank;
      logic            vec_load;
      logic [AW-1:0]   vec_addr;
      logic            hold;
      logic            pready;
      logic            pslverr;
      logic [31:0]     prdata;
   } mlic_state_s;

   mlic_state_s r;
   mlic_state_s nxt;

   logic [N-1:0]  nmi_req;
   logic [N-1:0]  hi_req;
   logic [N-1:0]  med_req;
   logic [N-1:0]  lo_req;
   logic [3:0]    found;
   logic [IW-1:0] idx [4];
   logic [IW-1:0] lo_start;
   logic [2:0]    cur_rank;
   logic          nmi_ok;
   logic          hi_ok;
   logic          med_ok;
   logic          lo_ok;
   logic          blocked;
   logic          take;
   logic          apb_go;
   logic [9:0]    word_idx;
   logic [N-1:0]  clr;

   // Request masks per level; code 00 keeps a source out of every mask
   always_comb begin
      for (int i = 0; i < N; i++) begin
         nmi_req[i] = r.flag[i] && NMI_MASK[i] && (r.lvl[2*i +: 2] != MLIC_LVL_OFF);
         hi_req[i]  = r.flag[i] && !NMI_MASK[i] && (r.lvl[2*i +: 2] == MLIC_LVL_HI);
         med_req[i] = r.flag[i] && !NMI_MASK[i] && (r.lvl[2*i +: 2] == MLIC_LVL_MED);
         lo_req[i]  = r.flag[i] && !NMI_MASK[i] && (r.lvl[2*i +: 2] == MLIC_LVL_LO);
      end
   end

   // Start just past the last low winner; static mode starts at index zero
   assign lo_start = r.rren ? IW'((int'(r.intpri[IW-1:0]) + 1) % N) : '0;

   mlic_arbiter #(.N(N), .IW(IW)) u_arb_nmi (
      .req_in(nmi_req), .start_in('0), .found_out(found[3]), .idx_out(idx[3]));
   mlic_arbiter #(.N(N), .IW(IW)) u_arb_hi (
      .req_in(hi_req), .start_in('0), .found_out(found[2]), .idx_out(idx[2]));
   mlic_arbiter #(.N(N), .IW(IW)) u_arb_med (
      .req_in(med_req), .start_in('0), .found_out(found[1]), .idx_out(idx[1]));
   mlic_arbiter #(.N(N), .IW(IW)) u_arb_lo (
      .req_in(lo_req), .start_in(lo_start), .found_out(found[0]), .idx_out(idx[0]));

   assign cur_rank = r.nmi_ex ? MLIC_RANK_NMI :
                     r.hi_ex  ? MLIC_RANK_HI  :
                     r.med_ex ? MLIC_RANK_MED :
                     r.lo_ex  ? MLIC_RANK_LO  : MLIC_RANK_NONE;

   // A request wins only above the running rank
   assign nmi_ok  = found[3] && (cur_rank < MLIC_RANK_NMI);
   assign hi_ok   = found[2] && gie_in && r.hi_en  && (cur_rank < MLIC_RANK_HI);
   assign med_ok  = found[1] && gie_in && r.med_en && (cur_rank < MLIC_RANK_MED);
   assign lo_ok   = found[0] && gie_in && r.lo_en  && (cur_rank < MLIC_RANK_LO);
   assign blocked = (r.ccp_cnt != 3'h0) || locked_exec_in || !r.instr_done;
   assign take    = (r.st == MLIC_ST_IDLE) && !interrupt_return_instr_in && !blocked &&
                    (nmi_ok || hi_ok || med_ok || lo_ok);

   assign apb_go   = psel_in && penable_in && r.pready;
   assign word_idx = paddr_in[11:2];

   always_comb begin
      nxt          = r;
      clr          = access_clr_in;
      nxt.vec_load = 1'b0;
      nxt.ccp_cnt  = ccp_sig_in ? MLIC_CCP_CYC :
                     (r.ccp_cnt != 3'h0) ? r.ccp_cnt - 3'h1 : 3'h0;
      nxt.instr_done = r.instr_done || instr_retire_in;

      unique case (r.st)
         MLIC_ST_IDLE: begin
            if (interrupt_return_instr_in) begin
               nxt.st  = MLIC_ST_INTERRUPT_RETURN_INSTR;
               nxt.cnt = (WIDE_PC ? MLIC_INTERRUPT_RETURN_INSTR_LONG : MLIC_INTERRUPT_RETURN_INSTR_SHORT) - 8'h01;
            end else if (take) begin
               nxt.st  = sleep_in ? MLIC_ST_WAKE : MLIC_ST_FINISH;
               nxt.cnt = sleep_in ? MLIC_WAKE_CYC + STARTUP_CYC - 8'h01 :
                                    MLIC_FINISH_CYC - 8'h01;
               if (nmi_ok) begin
                  nxt.sel      = idx[3];
                  nxt.sel_rank = MLIC_RANK_NMI;
               end else if (hi_ok) begin
                  nxt.sel      = idx[2];
                  nxt.sel_rank = MLIC_RANK_HI;
               end else if (med_ok) begin
                  nxt.sel      = idx[1];
                  nxt.sel_rank = MLIC_RANK_MED;
               end else begin
                  nxt.sel      = idx[0];
                  nxt.sel_rank = MLIC_RANK_LO;
               end
            end
         end
         MLIC_ST_WAKE: begin
            if (r.cnt == 8'h00) begin
               nxt.st  = MLIC_ST_FINISH;
               nxt.cnt = MLIC_FINISH_CYC - 8'h01;
            end else begin
               nxt.cnt = r.cnt - 8'h01;
            end
         end
         MLIC_ST_FINISH: begin
            if (r.cnt == 8'h00) begin
               nxt.st  = MLIC_ST_PUSH;
               nxt.cnt = MLIC_PUSH_CYC - 8'h01;
            end else begin
               nxt.cnt = r.cnt - 8'h01;
            end
         end
         MLIC_ST_PUSH: begin
            if (r.cnt == 8'h00) begin
               // Acknowledge; the global enable is left as it is
               nxt.st         = MLIC_ST_JUMP;
               nxt.cnt        = MLIC_JUMP_CYC - 8'h01;
               nxt.vec_load   = 1'b1;
               nxt.vec_addr   = (r.ivsel ? BOOT_BASE : APP_BASE) +
                                AW'(32'(r.sel) + 32'd1) * VEC_STRIDE;
               nxt.instr_done = 1'b0;
               nxt.nmi_ex     = r.nmi_ex || (r.sel_rank == MLIC_RANK_NMI);
               nxt.hi_ex      = r.hi_ex  || (r.sel_rank == MLIC_RANK_HI);
               nxt.med_ex     = r.med_ex || (r.sel_rank == MLIC_RANK_MED);
               nxt.lo_ex      = r.lo_ex  || (r.sel_rank == MLIC_RANK_LO);
               if (r.sel_rank == MLIC_RANK_LO) begin
                  nxt.intpri = 8'(r.sel);
               end
               if (AUTOCLR[r.sel]) begin
                  clr[r.sel] = 1'b1;
               end
            end else begin
               nxt.cnt = r.cnt - 8'h01;
            end
         end
         MLIC_ST_JUMP: begin
            if (r.cnt == 8'h00) begin
               nxt.st = MLIC_ST_IDLE;
            end else begin
               nxt.cnt = r.cnt - 8'h01;
            end
         end
         MLIC_ST_INTERRUPT_RETURN_INSTR: begin
            if (r.cnt == 8'h00) begin
               // Only the innermost level unwinds
               nxt.st         = MLIC_ST_IDLE;
               nxt.instr_done = 1'b0;
               if (r.nmi_ex) begin
                  nxt.nmi_ex = 1'b0;
               end else if (r.hi_ex) begin
                  nxt.hi_ex = 1'b0;
               end else if (r.med_ex) begin
                  nxt.med_ex = 1'b0;
               end else begin
                  nxt.lo_ex = 1'b0;
               end
            end else begin
               nxt.cnt = r.cnt - 8'h01;
            end
         end
         default: nxt.st = MLIC_ST_IDLE;
      endcase

      // APB: one wait cycle, then the access completes
      nxt.pready  = psel_in && penable_in && !r.pready;
      nxt.pslverr = 1'b0;
      nxt.prdata  = MLIC_RST_WORD;
      if (nxt.pready) begin
         unique case (word_idx)
            10'(MLIC_IDX_STATUS): begin
               nxt.prdata[MLIC_ST_NMI_BIT] = r.nmi_ex;
               nxt.prdata[MLIC_ST_HI_BIT]  = r.hi_ex;
               nxt.prdata[MLIC_ST_MED_BIT] = r.med_ex;
               nxt.prdata[MLIC_ST_LO_BIT]  = r.lo_ex;
            end
            10'(MLIC_IDX_INTPRI): nxt.prdata[7:0] = r.intpri;
            10'(MLIC_IDX_CTRL): begin
               nxt.prdata[MLIC_CT_RREN_BIT]  = r.rren;
               nxt.prdata[MLIC_CT_IVSEL_BIT] = r.ivsel;
               nxt.prdata[MLIC_CT_HI_BIT]    = r.hi_en;
               nxt.prdata[MLIC_CT_MED_BIT]   = r.med_en;
               nxt.prdata[MLIC_CT_LO_BIT]    = r.lo_en;
            end
            10'(MLIC_IDX_LEVEL):  nxt.prdata[2*N-1:0] = r.lvl;
            10'(MLIC_IDX_FLAG):   nxt.prdata[N-1:0]   = r.flag;
            default:              nxt.pslverr = 1'b1;
         endcase
      end
      if (apb_go && pwrite_in) begin
         unique case (word_idx)
            10'(MLIC_IDX_INTPRI): nxt.intpri = pwdata_in[7:0];
            10'(MLIC_IDX_CTRL): begin
               nxt.rren   = pwdata_in[MLIC_CT_RREN_BIT];
               nxt.hi_en  = pwdata_in[MLIC_CT_HI_BIT];
               nxt.med_en = pwdata_in[MLIC_CT_MED_BIT];
               nxt.lo_en  = pwdata_in[MLIC_CT_LO_BIT];
               // Vector select moves only inside the protection window
               if (r.ccp_cnt != 3'h0) begin
                  nxt.ivsel = pwdata_in[MLIC_CT_IVSEL_BIT];
               end
            end
            10'(MLIC_IDX_LEVEL): nxt.lvl = pwdata_in[2*N-1:0];
            10'(MLIC_IDX_FLAG):  clr     = clr | pwdata_in[N-1:0];
            default: ;
         endcase
      end

      // New condition beats any clear in the same cycle
      nxt.flag = (r.flag & ~clr) | irq_cond_in;
      nxt.hold = (nxt.st != MLIC_ST_IDLE);
   end

   always_ff @(posedge sys_clk_in) begin
      if (!rst_b_in) begin
         r <= '0;
      end else begin
         r <= nxt;
      end
   end

   assign prdata_out      = r.prdata;
   assign pready_out      = r.pready;
   assign pslverr_out     = r.pslverr;
   assign vec_load_out    = r.vec_load;
   assign vec_addr_out    = r.vec_addr;
   assign cpu_hold_out    = r.hold;
   assign exec_status_out = {r.nmi_ex, r.hi_ex, r.med_ex, r.lo_ex};

   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!rst_b_in);

   chk_gie_gates_maskable: assert property (take && !nmi_ok |-> gie_in)
      else $error("maskable interrupt taken with global enable low");
   chk_level_enable_hi: assert property (take && (nxt.sel_rank != MLIC_RANK_NMI) |->
      ((nxt.sel_rank == MLIC_RANK_HI) ? r.hi_en : (nxt.sel_rank == MLIC_RANK_MED) ? r.med_en : r.lo_en))
      else $error("level taken while its enable is off");
   chk_preempt_rank: assert property (
      (r.st == MLIC_ST_IDLE) && (nxt.st == MLIC_ST_FINISH || nxt.st == MLIC_ST_WAKE)
      |-> nxt.sel_rank > cur_rank)
      else $error("request taken without higher level");
   chk_one_instr_first: assert property (take |-> r.instr_done && $past(r.st) != MLIC_ST_INTERRUPT_RETURN_INSTR)
      else $error("interrupt taken before an instruction retired");
   chk_resp_three: assert property (
      (r.st == MLIC_ST_FINISH) && ($past(r.st) != MLIC_ST_FINISH)
      |-> ##1 (r.st == MLIC_ST_PUSH)[*2] ##1 r.vec_load)
      else $error("response sequence length wrong");
   chk_jump_three: assert property (r.vec_load |-> (r.st == MLIC_ST_JUMP)[*3] ##1 r.st == MLIC_ST_IDLE)
      else $error("jump phase not three cycles");
   chk_ccp_suppress: assert property (ccp_sig_in |=> (!take)[*4])
      else $error("interrupt taken inside protection window");
   chk_flag_set_wins: assert property (
      irq_cond_in != '0 |=> (r.flag & $past(irq_cond_in)) == $past(irq_cond_in))
      else $error("flag lost on condition");
   chk_nmi_not_preempted: assert property (r.nmi_ex && r.st == MLIC_ST_IDLE |-> !take)
      else $error("NMI handler preempted");
   chk_interrupt_return_instr_unwind: assert property (
      (r.st == MLIC_ST_INTERRUPT_RETURN_INSTR) && ($past(r.st) == MLIC_ST_IDLE) && r.hi_ex && !r.nmi_ex
      |-> ##[3:4] (r.st == MLIC_ST_IDLE) && !r.hi_ex)
      else $error("return did not unwind high level in time");

   chk_wake_len: assert property (
      (r.st == MLIC_ST_WAKE) && ($past(r.st) == MLIC_ST_IDLE) |-> ##WAKE_LEN (r.st == MLIC_ST_FINISH))
      else $error("wake phase length wrong");

   cov_nmi_entry: cover property (take && nmi_ok);
   cov_lo_preempted: cover property (r.lo_ex && take && hi_ok);
   cov_rr_rotate: cover property (r.rren && r.vec_load && r.sel_rank == MLIC_RANK_LO);
   cov_sleep_wake: cover property (r.st == MLIC_ST_WAKE);
endmodule // multilevel_irq_ctrl

// [dv/mlic_cpu_model.sv]
/*
 CPU core model facing the controller: retires one instruction per free cycle, issues interrupt returns.
 Assumes the controller stalls it through its hold output; the bench asks for each return.
*/
`timescale 1ns/1ns
module mlic_cpu_model (
   input  wire logic clk_in,
   input  wire logic rst_b_in,
   input  wire logic hold_in,
   input  wire logic ret_req_in,
   output logic      retire_out,
   output logic      interrupt_return_instr_out
);
   always_ff @(posedge clk_in) begin
      if (!rst_b_in) begin
         retire_out <= 1'b0;
         interrupt_return_instr_out   <= 1'b0;
      end else begin
         // Handlers end with the interrupt return, never a plain return
         interrupt_return_instr_out   <= ret_req_in && !hold_in && !interrupt_return_instr_out;
         // Status register saving is handler code, nothing to do here
         retire_out <= !hold_in;
      end
   end
endmodule // mlic_cpu_model

// [dv/test_multilevel_irq_ctrl.sv]
/*
 Self-checking bench: APB register tasks and interrupt sequences with expected vectors.
 Assumes design defaults: N=8, APP_BASE=0, VEC_STRIDE=2, source 0 non-maskable.
*/
`timescale 1ns/1ns
module test_multilevel_irq_ctrl;
   import mlic_pkg::*;
   logic        clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rdv;
   logic        pready, pslverr, gie = 1'b0, ret_req = 1'b0, vload, hold, retire, interrupt_return_instr, errv;
   logic [7:0]  cond = 8'h00;
   logic [15:0] vaddr, last_vec = 16'h0;
   logic [3:0]  xst;
   logic        sleep = 1'b0, ccp = 1'b0, locked = 1'b0;
   logic [7:0]  aclr = 8'h00;
   int          miscompares = 0, checks_done = 0, nvec = 0, cycles = 0;

   multilevel_irq_ctrl i_dut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
      .pslverr_out(pslverr), .gie_in(gie), .instr_retire_in(retire), .interrupt_return_instr_in(interrupt_return_instr), .sleep_in(sleep),
      .ccp_sig_in(ccp), .locked_exec_in(locked), .irq_cond_in(cond), .access_clr_in(aclr),
      .vec_load_out(vload), .vec_addr_out(vaddr), .cpu_hold_out(hold), .exec_status_out(xst));
   mlic_cpu_model i_cpu (.clk_in(clk), .rst_b_in(rst_b), .hold_in(hold), .ret_req_in(ret_req),
      .retire_out(retire), .interrupt_return_instr_out(interrupt_return_instr));

   always #5 clk = ~clk;
   // Sampled mid-cycle so the one-cycle pulse is never missed
   always @(negedge clk) begin
      if (vload === 1'b1) begin
         nvec++;
         last_vec = vaddr;
         chk({31'h0, hold}, 32'h1);
      end
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         miscompares++;
         close_out();
      end
   end

   task automatic close_out();
      if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Holds the request until pready is seen at an edge; one idle edge after
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rdv = prdata;
      errv = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rchk(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdv, exp);
   endtask
   task automatic pulse(input logic [7:0] m);
      cond <= m;
      @(posedge clk);
      cond <= 8'h00;
      @(posedge clk);
   endtask
   task automatic expect_vec(input int n, input logic [15:0] a);
      int k;
      k = 0;
      while (nvec < n && k < 60) begin
         @(posedge clk);
         k++;
      end
      chk(32'(nvec), 32'(n));
      chk({16'h0, last_vec}, {16'h0, a});
   endtask
   task automatic ret_int();
      while (hold !== 1'b0) begin
         @(posedge clk);
      end
      ret_req <= 1'b1;
      @(posedge clk);
      ret_req <= 1'b0;
      repeat (10) @(posedge clk);
   endtask

   initial begin
      repeat (3) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 5; i++) rchk(i[7:0], MLIC_RST_WORD);
      rchk(8'h05, 32'h0);
      chk({31'h0, errv}, 32'h1);
      apb(1'b1, MLIC_IDX_LEVEL, 32'h0000_0f91);
      apb(1'b1, MLIC_IDX_CTRL, 32'h0000_0007);
      pulse(8'h34);
      repeat (20) @(posedge clk);
      chk(32'(nvec), 32'h0);
      rchk(MLIC_IDX_FLAG, 32'h34);
      gie <= 1'b1;
      expect_vec(1, 16'h000a);
      rchk(MLIC_IDX_STATUS, 32'h4);
      ret_int();
      expect_vec(2, 16'h000c);
      ret_int();
      expect_vec(3, 16'h0006);
      pulse(8'h08);
      expect_vec(4, 16'h0008);
      chk({28'h0, xst}, 32'h3);
      rchk(MLIC_IDX_STATUS, 32'h3);
      ret_int();
      rchk(MLIC_IDX_STATUS, 32'h1);
      ret_int();
      rchk(MLIC_IDX_FLAG, 32'h0);
      gie <= 1'b0;
      pulse(8'h01);
      expect_vec(5, 16'h0002);
      rchk(MLIC_IDX_STATUS, 32'h80);
      chk({28'h0, xst}, 32'h8);
      gie <= 1'b1;
      pulse(8'h10);
      repeat (20) @(posedge clk);
      chk(32'(nvec), 32'h5);
      ret_int();
      expect_vec(6, 16'h000a);
      ret_int();
      apb(1'b1, MLIC_IDX_CTRL, 32'h0000_0006);
      pulse(8'h04);
      repeat (20) @(posedge clk);
      chk(32'(nvec), 32'h6);
      apb(1'b1, MLIC_IDX_FLAG, 32'h0000_0004);
      rchk(MLIC_IDX_FLAG, 32'h0);
      pulse(8'h04);
      aclr <= 8'h04;
      @(posedge clk);
      aclr <= 8'h00;
      rchk(MLIC_IDX_FLAG, 32'h0);
      apb(1'b1, MLIC_IDX_LEVEL, 32'h0000_1011);
      apb(1'b1, MLIC_IDX_CTRL, 32'h0000_00c1);
      rchk(MLIC_IDX_CTRL, 32'h81);
      pulse(8'h44);
      expect_vec(7, 16'h000e);
      rchk(MLIC_IDX_INTPRI, 32'h6);
      ret_int();
      expect_vec(8, 16'h0006);
      ret_int();
      locked <= 1'b1;
      pulse(8'h04);
      repeat (20) @(posedge clk);
      chk(32'(nvec), 32'h8);
      ccp <= 1'b1;
      @(posedge clk);
      ccp <= 1'b0;
      apb(1'b1, MLIC_IDX_CTRL, 32'h0000_00c1);
      locked <= 1'b0;
      expect_vec(9, 16'h1006);
      rchk(MLIC_IDX_CTRL, 32'hc1);
      ret_int();
      sleep <= 1'b1;
      pulse(8'h04);
      expect_vec(10, 16'h1006);
      sleep <= 1'b0;
      ret_int();
      close_out();
   end
endmodule // test_multilevel_irq_ctrl
